// ### rtl/nalu_adder.sv
`timescale 1ns/1ps

// 4-bit adder with carry in; carry out is "no borrow" when b is inverted
module nalu_adder (
  input  wire logic [3:0] op_a,
  input  wire logic [3:0] op_b,
  input  wire logic       cin,
  output logic      [3:0] sum,
  output logic            cout
);

  logic [4:0] full;

  // Wide sum, split into nibble and carry
  assign full = {1'b0, op_a} + {1'b0, op_b} + {4'h0, cin};
  assign sum  = full[3:0];
  assign cout = full[4];

endmodule : nalu_adder

// ### rtl/nalu_defs.svh
`ifndef NALU_DEFS_SVH
`define NALU_DEFS_SVH

// APB register byte offsets
`define NALU_OFF_INSTR   12'h000
`define NALU_OFF_ACC     12'h004
`define NALU_OFF_PTR_L   12'h008
`define NALU_OFF_PTR_H   12'h00c
`define NALU_OFF_FLAGS   12'h010
`define NALU_OFF_PORT    12'h014
`define NALU_OFF_STATUS  12'h018
`define NALU_OFF_RAM     12'h080
`define NALU_RAM_END     12'h0fc

// Field positions
`define NALU_FLG_JCF     0
`define NALU_FLG_SEC     1
`define NALU_STS_UNSUP   0
`define NALU_STS_CNT_LO  8
`define NALU_STS_CNT_HI  15

// Reset values
`define NALU_RST_NIB     4'h0
`define NALU_RST_JCF     1'b1
`define NALU_RST_SEC     1'b0
`define NALU_RST_INSTR   8'h00

// Opcodes
`define NALU_OPC_ADD_MEM  8'h06
`define NALU_OPC_INC_L    8'h05
`define NALU_OPC_DEC_L    8'h04
`define NALU_OPC_DEC_MEM  8'h07
`define NALU_OPC_NOT_H    8'h09
`define NALU_OPC_PORT     8'h0a
`define NALU_OPC_SUB_MEM  8'h3c
`define NALU_OPC_NEG_A    8'h3d
`define NALU_OPC_INC_MEM  8'h3e
`define NALU_OPC_INC_A    8'h70
`define NALU_OPC_DEC_A    8'h77
`define NALU_OPC_ZERO_A   8'h7f
`define NALU_PAT_ADD_IMM  4'h7
`define NALU_PAT_BIT_SET  6'h0c
`define NALU_PAT_BIT_CLR  6'h0d

// Sizes
`define NALU_RAM_DEPTH   32
`define NALU_RAM_AW      5

`endif

// ### rtl/nalu_pkg.sv
package nalu_pkg;

  // Instruction classes handled by this datapath
  typedef enum logic [3:0] {
    NALU_OP_NONE,
    NALU_OP_PORT,
    NALU_OP_NEG_A,
    NALU_OP_NOT_H,
    NALU_OP_ZERO_A,
    NALU_OP_ADD_MEM,
    NALU_OP_ADD_IMM,
    NALU_OP_SUB_MEM,
    NALU_OP_INC_MEM,
    NALU_OP_INC_L,
    NALU_OP_INC_A,
    NALU_OP_DEC_A,
    NALU_OP_DEC_MEM,
    NALU_OP_DEC_L,
    NALU_OP_BIT_SET,
    NALU_OP_BIT_CLR
  } nalu_op_t;

endpackage : nalu_pkg

// ### rtl/nalu_ram.sv
`timescale 1ns/1ps
`include "nalu_defs.svh"

// Nibble data memory, one write port, one asynchronous read port
module nalu_ram (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     wr_en,
  input  wire logic [`NALU_RAM_AW-1:0]  wr_addr,
  input  wire logic [3:0]               wr_data,
  input  wire logic [`NALU_RAM_AW-1:0]  rd_addr,
  output logic      [3:0]               rd_data
);

  logic [3:0] mem_ff [`NALU_RAM_DEPTH];

  // Storage, cleared at reset so reads are never undefined
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `NALU_RAM_DEPTH; i++) begin
        mem_ff[i] <= `NALU_RST_NIB;
      end
    end else if (wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem_ff[rd_addr];

endmodule : nalu_ram

// ### rtl/nalu_top.sv
`timescale 1ns/1ps
`include "nalu_defs.svh"

// Notes on behaviour
// RQ1 - Port-load opcode loads output port with accumulator plus secondary flag.
// RQ2 - Port load, clear, pointer invert, bit set/clear force jump flag to one.
// RQ3 - Negate opcode forms two's complement; jump flag set when result is zero.
// RQ4 - Pointer invert flips only the top bit of the high pointer.
// RQ5 - Clear opcode writes zero to the accumulator.
// RQ6 - Add-memory sums RAM nibble into accumulator; jump flag is carry out.
// RQ7 - Add-immediate sums low opcode nibble into accumulator; jump flag is carry.
// RQ8 - Subtract-from-memory gives RAM minus accumulator; jump flag means no borrow.
// RQ9 - Increment-memory puts RAM plus one in accumulator; jump flag is carry.
// RQ10 - Increment low pointer; jump flag is carry out.
// RQ11 - Increment accumulator by one.
// RQ12 - Decrement accumulator by one.
// RQ13 - Decrement-memory puts RAM minus one in accumulator; RAM untouched.
// RQ14 - Decrement low pointer; jump flag means no borrow.
// RQ15 - Bit-set opcode sets selected bit of addressed RAM nibble.
// RQ16 - Bit-clear opcode clears selected bit of addressed RAM nibble.
// RQ17 - RAM address is high pointer bit 0 joined with low pointer.
// RQ18 - Arithmetic wraps modulo sixteen; inc/dec flags follow carry or no-borrow.
// RQ19 - Secondary flag changes only on a FLAGS write; each opcode completes in one cycle.
module nalu_top
  import nalu_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [3:0]  parallel_output_port,
  output logic             jump_condition_flag,
  output logic             secondary_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Map an opcode to its class; specific codes win over the immediate pattern
  function automatic nalu_op_t op_decode(input logic [7:0] opc);
    nalu_op_t op;
    op = NALU_OP_NONE;
    case (opc)
      `NALU_OPC_PORT:    op = NALU_OP_PORT;
      `NALU_OPC_NEG_A:   op = NALU_OP_NEG_A;
      `NALU_OPC_NOT_H:   op = NALU_OP_NOT_H;
      `NALU_OPC_ZERO_A:  op = NALU_OP_ZERO_A;
      `NALU_OPC_ADD_MEM: op = NALU_OP_ADD_MEM;
      `NALU_OPC_SUB_MEM: op = NALU_OP_SUB_MEM;
      `NALU_OPC_INC_MEM: op = NALU_OP_INC_MEM;
      `NALU_OPC_INC_L:   op = NALU_OP_INC_L;
      `NALU_OPC_INC_A:   op = NALU_OP_INC_A;
      `NALU_OPC_DEC_A:   op = NALU_OP_DEC_A;
      `NALU_OPC_DEC_MEM: op = NALU_OP_DEC_MEM;
      `NALU_OPC_DEC_L:   op = NALU_OP_DEC_L;
      default: begin
        if (opc[7:4] == `NALU_PAT_ADD_IMM) begin
          op = NALU_OP_ADD_IMM;
        end else if (opc[7:2] == `NALU_PAT_BIT_SET) begin
          op = NALU_OP_BIT_SET;
        end else if (opc[7:2] == `NALU_PAT_BIT_CLR) begin
          op = NALU_OP_BIT_CLR;
        end else begin
          op = NALU_OP_NONE;
        end
      end
    endcase
    return op;
  endfunction : op_decode

  // Word-aligned register hit test
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
    return addr == off;
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // State and wires

  logic [3:0]  acc_ff;
  logic [3:0]  ptr_l_ff;
  logic [3:0]  ptr_h_ff;
  logic        jcf_ff;
  logic        sec_ff;
  logic [3:0]  port_ff;
  logic [7:0]  instr_ff;
  logic        unsup_ff;
  logic [7:0]  count_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;

  logic        setup;
  logic        wr_done;
  logic        is_ram;
  logic        mapped;
  logic        exec;
  nalu_op_t    op;
  logic [`NALU_RAM_AW-1:0] ram_ptr;
  logic [`NALU_RAM_AW-1:0] ram_rd_addr;
  logic [`NALU_RAM_AW-1:0] apb_ram_addr;
  logic [3:0]  ram_rd;
  logic        ram_we;
  logic [`NALU_RAM_AW-1:0] ram_wa;
  logic [3:0]  ram_wd;
  logic [3:0]  add_a;
  logic [3:0]  add_b;
  logic        add_ci;
  logic [3:0]  add_s;
  logic        add_co;
  logic [3:0]  bit_mask;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  assign setup        = psel & ~penable;
  assign wr_done      = psel & penable & pready_ff & pwrite & ~pslverr_ff;
  assign is_ram       = (paddr >= `NALU_OFF_RAM) && (paddr <= `NALU_RAM_END)
                        && (paddr[1:0] == 2'h0);
  assign apb_ram_addr = paddr[`NALU_RAM_AW+1:2];
  assign mapped       = is_ram || hit(paddr, `NALU_OFF_INSTR)
                        || hit(paddr, `NALU_OFF_ACC) || hit(paddr, `NALU_OFF_PTR_L)
                        || hit(paddr, `NALU_OFF_PTR_H) || hit(paddr, `NALU_OFF_FLAGS)
                        || hit(paddr, `NALU_OFF_PORT) || hit(paddr, `NALU_OFF_STATUS);
  assign exec         = wr_done & hit(paddr, `NALU_OFF_INSTR);
  assign op           = exec ? op_decode(pwdata[7:0]) : NALU_OP_NONE;

  ////////////////////////////////////////////////////////////////////////////
  // Datapath

  // Indirect address: high pointer low bit joined with the low pointer
  assign ram_ptr     = {ptr_h_ff[0], ptr_l_ff}; // [RQ17]
  assign ram_rd_addr = (psel && is_ram) ? apb_ram_addr : ram_ptr;
  assign bit_mask    = 4'h1 << pwdata[1:0];

  // Adder operand steering, all results wrap to four bits
  always_comb begin
    add_a  = acc_ff;
    add_b  = 4'h0;
    add_ci = 1'b0;
    case (op)
      NALU_OP_PORT:    add_ci = sec_ff;                                 // [RQ1]
      NALU_OP_NEG_A: begin
        add_a  = ~acc_ff;                                               // [RQ3]
        add_ci = 1'b1;
      end
      NALU_OP_ADD_MEM: add_b = ram_rd;                                  // [RQ6]
      NALU_OP_ADD_IMM: add_b = pwdata[3:0];                             // [RQ7]
      NALU_OP_SUB_MEM: begin
        add_a  = ram_rd;                                                // [RQ8]
        add_b  = ~acc_ff;
        add_ci = 1'b1;
      end
      NALU_OP_INC_MEM: begin
        add_a  = ram_rd;                                                // [RQ9]
        add_ci = 1'b1;
      end
      NALU_OP_INC_L: begin
        add_a  = ptr_l_ff;                                              // [RQ10]
        add_ci = 1'b1;
      end
      NALU_OP_INC_A:   add_ci = 1'b1;                                   // [RQ11]
      NALU_OP_DEC_A:   add_b = 4'hf;                                    // [RQ12]
      NALU_OP_DEC_MEM: begin
        add_a = ram_rd;                                                 // [RQ13]
        add_b = 4'hf;
      end
      NALU_OP_DEC_L: begin
        add_a = ptr_l_ff;                                               // [RQ14]
        add_b = 4'hf;
      end
      default: begin
        add_a  = acc_ff;
        add_b  = 4'h0;
        add_ci = 1'b0;
      end
    endcase
  end

  nalu_adder u_adder (
    .op_a (add_a),
    .op_b (add_b),
    .cin  (add_ci),
    .sum  (add_s),
    .cout (add_co)
  );

  // RAM write steering: bit ops from the core, whole words from APB
  always_comb begin
    ram_we = 1'b0;
    ram_wa = ram_ptr;
    ram_wd = ram_rd;
    if (op == NALU_OP_BIT_SET) begin
      ram_we = 1'b1;
      ram_wd = ram_rd | bit_mask;                                       // [RQ15]
    end else if (op == NALU_OP_BIT_CLR) begin
      ram_we = 1'b1;
      ram_wd = ram_rd & ~bit_mask;                                      // [RQ16]
    end else if (wr_done && is_ram) begin
      ram_we = 1'b1;
      ram_wa = apb_ram_addr;
      ram_wd = pwdata[3:0];
    end
  end

  nalu_ram u_ram (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (ram_we),
    .wr_addr (ram_wa),
    .wr_data (ram_wd),
    .rd_addr (ram_rd_addr),
    .rd_data (ram_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Architectural registers, updated in the cycle the opcode is written

  // Accumulator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_ff <= `NALU_RST_NIB;
    end else begin
      case (op)
        NALU_OP_ZERO_A: acc_ff <= 4'h0;                                 // [RQ5]
        NALU_OP_NEG_A, NALU_OP_ADD_MEM, NALU_OP_ADD_IMM, NALU_OP_SUB_MEM,
        NALU_OP_INC_MEM, NALU_OP_INC_A, NALU_OP_DEC_A, NALU_OP_DEC_MEM: begin
          acc_ff <= add_s;                                              // [RQ18] [RQ19]
        end
        default: begin
          if (wr_done && hit(paddr, `NALU_OFF_ACC)) begin
            acc_ff <= pwdata[3:0];
          end
        end
      endcase
    end
  end

  // Low and high pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_l_ff <= `NALU_RST_NIB;
      ptr_h_ff <= `NALU_RST_NIB;
    end else begin
      if (op == NALU_OP_INC_L || op == NALU_OP_DEC_L) begin
        ptr_l_ff <= add_s;                                              // [RQ10] [RQ14]
      end else if (wr_done && hit(paddr, `NALU_OFF_PTR_L)) begin
        ptr_l_ff <= pwdata[3:0];
      end
      if (op == NALU_OP_NOT_H) begin
        ptr_h_ff <= {~ptr_h_ff[3], ptr_h_ff[2:0]};                      // [RQ4]
      end else if (wr_done && hit(paddr, `NALU_OFF_PTR_H)) begin
        ptr_h_ff <= pwdata[3:0];
      end
    end
  end

  // Jump condition flag and secondary flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jcf_ff <= `NALU_RST_JCF;
      sec_ff <= `NALU_RST_SEC;
    end else begin
      case (op)
        NALU_OP_PORT, NALU_OP_ZERO_A, NALU_OP_NOT_H, NALU_OP_BIT_SET, NALU_OP_BIT_CLR: begin
          jcf_ff <= 1'b1;                                               // [RQ2]
        end
        NALU_OP_NEG_A: jcf_ff <= (add_s == 4'h0);                       // [RQ3]
        NALU_OP_ADD_MEM, NALU_OP_ADD_IMM, NALU_OP_SUB_MEM, NALU_OP_INC_MEM,
        NALU_OP_INC_L, NALU_OP_INC_A, NALU_OP_DEC_A, NALU_OP_DEC_MEM,
        NALU_OP_DEC_L: begin
          jcf_ff <= add_co;                                             // [RQ18]
        end
        default: begin
          if (wr_done && hit(paddr, `NALU_OFF_FLAGS)) begin
            jcf_ff <= pwdata[`NALU_FLG_JCF];
            sec_ff <= pwdata[`NALU_FLG_SEC];
          end
        end
      endcase
    end
  end

  // Parallel output port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_ff <= `NALU_RST_NIB;
    end else if (op == NALU_OP_PORT) begin
      port_ff <= add_s;                                                 // [RQ1]
    end
  end

  // Last opcode, unsupported marker and executed-opcode counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_ff <= `NALU_RST_INSTR;
      unsup_ff <= 1'b0;
      count_ff <= 8'h00;
    end else if (exec) begin
      instr_ff <= pwdata[7:0];
      unsup_ff <= (op == NALU_OP_NONE);
      count_ff <= count_ff + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: data captured in setup, ready in the first access cycle

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup & ~mapped;
      if (setup && !pwrite) begin
        prdata_ff <= 32'h0000_0000;
        if (is_ram) begin
          prdata_ff[3:0] <= ram_rd;
        end else if (hit(paddr, `NALU_OFF_INSTR)) begin
          prdata_ff[7:0] <= instr_ff;
        end else if (hit(paddr, `NALU_OFF_ACC)) begin
          prdata_ff[3:0] <= acc_ff;
        end else if (hit(paddr, `NALU_OFF_PTR_L)) begin
          prdata_ff[3:0] <= ptr_l_ff;
        end else if (hit(paddr, `NALU_OFF_PTR_H)) begin
          prdata_ff[3:0] <= ptr_h_ff;
        end else if (hit(paddr, `NALU_OFF_FLAGS)) begin
          prdata_ff[`NALU_FLG_JCF] <= jcf_ff;
          prdata_ff[`NALU_FLG_SEC] <= sec_ff;
        end else if (hit(paddr, `NALU_OFF_PORT)) begin
          prdata_ff[3:0] <= port_ff;
        end else if (hit(paddr, `NALU_OFF_STATUS)) begin
          prdata_ff[`NALU_STS_UNSUP] <= unsup_ff;
          prdata_ff[`NALU_STS_CNT_HI:`NALU_STS_CNT_LO] <= count_ff;
        end
      end
    end
  end

  assign prdata               = prdata_ff;
  assign pready               = pready_ff;
  assign pslverr              = pslverr_ff;
  assign parallel_output_port = port_ff;
  assign jump_condition_flag  = jcf_ff;
  assign secondary_flag       = sec_ff;

endmodule : nalu_top

// ### sim/nalu_seq_model.sv
`timescale 1ns/1ps

// APB requester standing in for the instruction sequencer
module nalu_seq_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata
);
  // Idle bus from time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
  end

  // Setup, access, hold until ready is sampled, then release
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : nalu_seq_model

// ### sim/nalu_top_chk.sv
`timescale 1ns/1ps
`include "nalu_defs.svh"

// Port-level watcher for the nibble datapath
module nalu_top_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  parallel_output_port,
  input wire logic        jump_condition_flag,
  input wire logic        secondary_flag
);
  ////////////////////////////////////////
  // Decoded bus events
  logic       wr_go;
  logic [7:0] opc;
  assign wr_go = psel & penable & pwrite;
  assign opc   = pwdata[7:0];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////
  // Handshake shape
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no ready one cycle after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_no_err_instr: assert property (pready && paddr == `NALU_OFF_INSTR |-> !pslverr)
    else $error("error on opcode register");

  // Flag and port effects of executed opcodes
  a_flag_forced: assert property (wr_go && paddr == `NALU_OFF_INSTR &&
    (opc inside {8'h0a, 8'h09, 8'h7f} || opc[7:3] == 5'b00110) |=> jump_condition_flag)
    else $error("jump flag not forced high");
  a_port_quiet: assert property (!(wr_go && paddr == `NALU_OFF_INSTR &&
    opc == 8'h0a) |=> $stable(parallel_output_port))
    else $error("port moved without port load");
  a_flag_quiet: assert property (!(wr_go && (paddr == `NALU_OFF_INSTR ||
    paddr == `NALU_OFF_FLAGS)) |=> $stable(jump_condition_flag))
    else $error("jump flag moved without cause");
  a_sec_quiet: assert property (!(wr_go && paddr == `NALU_OFF_FLAGS)
    |=> $stable(secondary_flag))
    else $error("secondary flag moved");
endmodule : nalu_top_chk

// ### sim/nalu_top_tb.sv
`timescale 1ns/1ps
`include "nalu_defs.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end

module nalu_top_tb;
  typedef struct packed {
    logic [7:0] opc;
    logic [3:0] a, l, h, m, ea, el, eh, em;
    logic       ej;
  } nalu_row_t;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        jump_condition_flag, secondary_flag;
  logic [11:0] paddr, ma;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  parallel_output_port;
  int          num_errors, checked, cycles;
  nalu_row_t   r;
  // Opcode, then a l h m before, a l h m after, jump flag after
  nalu_row_t   rows [24] = '{
    {8'h06, 32'h9308_1308, 1'b1}, {8'h06, 32'h2315_7315, 1'b0},
    {8'h7a, 32'h7100_1100, 1'b1}, {8'h73, 32'h4100_7100, 1'b0},
    {8'h3c, 32'h820c_420c, 1'b1}, {8'h3c, 32'h5203_e203, 1'b0},
    {8'h3d, 32'h7000_9000, 1'b0}, {8'h3d, 32'h0000_0000, 1'b1},
    {8'h3e, 32'h0406_7406, 1'b0}, {8'h3e, 32'h040f_040f, 1'b1},
    {8'h05, 32'h0500_0600, 1'b0}, {8'h05, 32'h0f00_0000, 1'b1},
    {8'h70, 32'h5000_6000, 1'b0}, {8'h70, 32'hf000_0000, 1'b1},
    {8'h77, 32'hb000_a000, 1'b1}, {8'h77, 32'h0000_f000, 1'b0},
    {8'h07, 32'h3a05_4a05, 1'b1}, {8'h07, 32'h3a00_fa00, 1'b0},
    {8'h04, 32'h0300_0200, 1'b1}, {8'h04, 32'h0000_0f00, 1'b0},
    {8'h09, 32'h0040_00c0, 1'b1}, {8'h09, 32'h00d0_0050, 1'b1},
    {8'h7f, 32'ha000_0000, 1'b1}, {8'h0a, 32'h6000_6000, 1'b1}};

  nalu_seq_model i_nalu_seq_model (.pclk(pclk), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  nalu_top i_nalu_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .parallel_output_port(parallel_output_port),
    .jump_condition_flag(jump_condition_flag), .secondary_flag(secondary_flag));

  ////////////////////////////////////////
  // Bus shorthands
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_nalu_seq_model.xfer(1'b1, a, d, rd, err);
  endtask : wr
  task automatic rdr(input logic [11:0] a);
    i_nalu_seq_model.xfer(1'b0, a, 32'h0, rd, err);
  endtask : rdr
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  // Clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  ////////////////////////////////////////
  // Main sequence
  initial begin
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      r  = rows[i];
      ma = `NALU_OFF_RAM + {5'h0, r.h[0], r.l, 2'b00};
      wr(`NALU_OFF_FLAGS, 32'h0);
      wr(`NALU_OFF_ACC, {28'h0, r.a});
      wr(`NALU_OFF_PTR_L, {28'h0, r.l});
      wr(`NALU_OFF_PTR_H, {28'h0, r.h});
      wr(ma, {28'h0, r.m});
      wr(`NALU_OFF_INSTR, {24'h0, r.opc});
      rdr(`NALU_OFF_ACC);
      `CHK(rd, {28'h0, r.ea})
      rdr(`NALU_OFF_PTR_L);
      `CHK(rd, {28'h0, r.el})
      rdr(`NALU_OFF_PTR_H);
      `CHK(rd, {28'h0, r.eh})
      rdr(ma);
      `CHK(rd, {28'h0, r.em})
      rdr(`NALU_OFF_FLAGS);
      `CHK(rd, {31'h0, r.ej})
    end
    $display("table done, %0d checks", checked);
    // Second reset in mid-run
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    `CHK({27'h0, parallel_output_port, jump_condition_flag}, 32'h1)
    rdr(`NALU_OFF_RAM + 12'h00c);
    `CHK(rd, 32'h0)
    $display("reset done");
    // Port load adds the secondary flag with wrap, flag untouched
    wr(`NALU_OFF_FLAGS, 32'h2);
    wr(`NALU_OFF_ACC, 32'hf);
    wr(`NALU_OFF_INSTR, 32'h0a);
    // The opcode lands at the edge the write ends on; look once it has settled
    @(negedge pclk);
    `CHK({26'h0, secondary_flag, jump_condition_flag, parallel_output_port}, 32'h30)
    wr(`NALU_OFF_ACC, 32'h5);
    wr(`NALU_OFF_INSTR, 32'h0a);
    rdr(`NALU_OFF_PORT);
    `CHK(rd, 32'h6)
    $display("port load done");
    // Every bit of set and clear
    wr(`NALU_OFF_PTR_H, 32'h0);
    wr(`NALU_OFF_PTR_L, 32'h7);
    for (int b = 0; b < 4; b++) begin
      wr(12'h09c, 32'h0);
      wr(`NALU_OFF_INSTR, 32'h30 | b);
      rdr(12'h09c);
      `CHK(rd, 32'h1 << b)
      wr(12'h09c, 32'hf);
      wr(`NALU_OFF_INSTR, 32'h34 | b);
      rdr(12'h09c);
      `CHK(rd, 32'hf ^ (32'h1 << b))
    end
    $display("bit ops done");
    // Unmapped place answers with an error and zero
    rdr(12'h040);
    `CHK({err, rd}, 33'h1_0000_0000)
    $display("unmapped done");
    // Unknown opcode marks STATUS, bumps the count and is kept in INSTR; accumulator keeps 5
    wr(`NALU_OFF_INSTR, 32'h0f);
    rdr(`NALU_OFF_STATUS);
    `CHK(rd, 32'h0b01)
    rdr(`NALU_OFF_INSTR);
    `CHK(rd, 32'h0f)
    rdr(`NALU_OFF_ACC);
    `CHK(rd, 32'h5)
    $display("unknown opcode done");
    wrap_up();
  end
endmodule : nalu_top_tb

bind nalu_top nalu_top_chk i_nalu_top_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .parallel_output_port(parallel_output_port),
  .jump_condition_flag(jump_condition_flag), .secondary_flag(secondary_flag));
